// >>> logic/fvcm_pkg.sv
// fvcm_pkg: page-zero layout, fault kinds and decimal/ASCII fault codes
// assumes a 16-bit word memory port and a 32-bit logical address
package fvcm_pkg;
  localparam logic [7:0] FVCM_RSV_LAST = 8'h27;
  localparam logic [7:0] FVCM_PZ_LAST = 8'hFF;
  localparam logic [7:0] FVCM_W_LEVEL = 8'h00;
  localparam logic [7:0] FVCM_W_IO_HND = 8'h01;
  localparam logic [7:0] FVCM_W_IO_RET_HI = 8'h02;
  localparam logic [7:0] FVCM_W_IO_RET_LO = 8'h03;
  localparam logic [7:0] FVCM_W_VSTK_PTR = 8'h04;
  localparam logic [7:0] FVCM_W_NMASK = 8'h05;
  localparam logic [7:0] FVCM_W_VSTK_LIM = 8'h06;
  localparam logic [7:0] FVCM_W_VSTK_HND = 8'h07;
  localparam logic [7:0] FVCM_W_BRK_HND = 8'h08;
  localparam logic [7:0] FVCM_W_WIDE_EXTENDED_OP_ORG = 8'h0A;
  localparam logic [7:0] FVCM_W_WSTK_HND = 8'h0C;
  localparam logic [7:0] FVCM_W_PAGE_HND = 8'h18;
  localparam logic [7:0] FVCM_W_CTX_BASE = 8'h1A;
  localparam logic [7:0] FVCM_W_GATE_PTR = 8'h1C;
  localparam logic [7:0] FVCM_W_PROT_HND = 8'h1E;
  localparam logic [7:0] FVCM_W_FIX_HND = 8'h1F;
  localparam logic [7:0] FVCM_W_NSTK_TOP = 8'h20;
  localparam logic [7:0] FVCM_W_NFRAME = 8'h21;
  localparam logic [7:0] FVCM_W_NSTK_LIM = 8'h22;
  localparam logic [7:0] FVCM_W_NSTK_HND = 8'h23;
  localparam logic [7:0] FVCM_W_NXOP_ORG = 8'h24;
  localparam logic [7:0] FVCM_W_FP_HND = 8'h25;
  localparam logic [7:0] FVCM_W_DEC_HND = 8'h26;
  localparam logic [7:0] FVCM_W_ERR_HND = 8'h27;
  localparam logic [15:0] FVCM_WIDE_BIT = 16'h8000;
  localparam logic [15:0] FVCM_DC_DIGIT_NARROW_FORMAT_A = 16'h0000;
  localparam logic [15:0] FVCM_DC_DTYPE = 16'h0001;
  localparam logic [15:0] FVCM_DC_SRC5 = 16'h0002;
  localparam logic [15:0] FVCM_DC_OPCODE = 16'h0003;
  localparam logic [15:0] FVCM_DC_RANGE = 16'h0004;
  localparam logic [15:0] FVCM_DC_RETBLK = 16'h0005;
  localparam logic [15:0] FVCM_DC_SIGN = 16'h0006;
  localparam logic [15:0] FVCM_DC_DIGIT = 16'h0007;
  localparam logic [1:0] FVCM_RB_TYPE_NARROW_FORMAT_A = 2'h2;
  localparam logic [2:0] FVCM_DTYPE_SRC_BAD = 3'h5;
  localparam logic [2:0] FVCM_DTYPE_6 = 3'h6;
  localparam logic [4:0] FVCM_IND_MAX = 5'h10;
  typedef enum logic [3:0] {
    FVCM_F_IO, FVCM_F_VSTK, FVCM_F_BRK, FVCM_F_WSTK, FVCM_F_PAGE, FVCM_F_PROT,
    FVCM_F_FIX, FVCM_F_NSTK, FVCM_F_FP, FVCM_F_DEC, FVCM_F_ERR
  } fvcm_fault_e;
  typedef enum logic [3:0] {
    FVCM_D_NONE, FVCM_D_BAD_CHAR, FVCM_D_DTYPE, FVCM_D_MOVE_SRC, FVCM_D_OPCODE,
    FVCM_D_RANGE, FVCM_D_RETBLK, FVCM_D_SIGN, FVCM_D_DIGIT, FVCM_D_SIGN_DIGIT
  } fvcm_dec_e;
  typedef struct packed {
    fvcm_fault_e kind;
    fvcm_dec_e dcond;
    logic wide;
    logic [2:0] seg;
    logic [15:0] size_prec;
  } fvcm_req_s;
  typedef struct packed {
    logic [31:0] target;
    logic [15:0] acc_one;
    logic [15:0] acc_two;
    logic acc_two_we;
    logic base_level;
  } fvcm_res_s;
endpackage : fvcm_pkg

// >>> logic/fvcm_dispatch.sv
// fvcm_dispatch: fault dispatch through page zero, decimal/ASCII fault codes
// assumes a word memory answering mem_rd_req with mem_rd_ok some cycles later
`timescale 1ns/1ps
`default_nettype none
module fvcm_dispatch (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fault_valid,
  input wire fvcm_pkg::fvcm_req_s fault_req,
  input wire logic xlate_en,
  output logic busy,
  output logic mem_rd_req,
  output logic [31:0] mem_addr,
  output logic mem_phys,
  input wire logic mem_rd_ok,
  input wire logic [15:0] mem_rd_data,
  output logic done,
  output fvcm_pkg::fvcm_res_s result,
  output logic bad_vector
);
  import fvcm_pkg::*;

  typedef enum {S_IDLE, S_LVL, S_RD, S_WAIT, S_LVL_WAIT, S_DONE} fvcm_state_e;
  fvcm_state_e state;
  fvcm_req_s req;
  logic [7:0] word;
  logic [2:0] seg;
  logic lvl_zero;
  logic [4:0] hops;

  function automatic logic [7:0] fvcm_slot(input fvcm_fault_e k);
    case (k)
      FVCM_F_IO: fvcm_slot = FVCM_W_IO_HND;
      FVCM_F_VSTK: fvcm_slot = FVCM_W_VSTK_HND;
      FVCM_F_BRK: fvcm_slot = FVCM_W_BRK_HND;
      FVCM_F_WSTK: fvcm_slot = FVCM_W_WSTK_HND;
      FVCM_F_PAGE: fvcm_slot = FVCM_W_PAGE_HND;
      FVCM_F_PROT: fvcm_slot = FVCM_W_PROT_HND;
      FVCM_F_FIX: fvcm_slot = FVCM_W_FIX_HND;
      FVCM_F_NSTK: fvcm_slot = FVCM_W_NSTK_HND;
      FVCM_F_FP: fvcm_slot = FVCM_W_FP_HND;
      FVCM_F_DEC: fvcm_slot = FVCM_W_DEC_HND;
      default: fvcm_slot = FVCM_W_ERR_HND;
    endcase
  endfunction : fvcm_slot

  // indirectable entries; page handler and error trap are used as fetched
  function automatic logic fvcm_indir(input fvcm_fault_e k);
    fvcm_indir = !(k == FVCM_F_PAGE || k == FVCM_F_ERR);
  endfunction : fvcm_indir

  function automatic logic [15:0] fvcm_dcode(input fvcm_dec_e c, input logic w);
    logic [15:0] n;
    n = FVCM_DC_DIGIT;
    case (c)
      FVCM_D_BAD_CHAR: n = FVCM_DC_DIGIT_NARROW_FORMAT_A;
      FVCM_D_DTYPE: n = FVCM_DC_DTYPE;
      FVCM_D_MOVE_SRC: n = FVCM_DC_SRC5;
      FVCM_D_OPCODE: n = FVCM_DC_OPCODE;
      FVCM_D_RANGE: n = FVCM_DC_RANGE;
      FVCM_D_RETBLK: n = FVCM_DC_RETBLK;
      FVCM_D_SIGN: n = FVCM_DC_SIGN;
      FVCM_D_SIGN_DIGIT: n = FVCM_DC_SIGN;
      default: n = FVCM_DC_DIGIT;
    endcase
    fvcm_dcode = (w && c != FVCM_D_RETBLK) ? (n | FVCM_WIDE_BIT) : n;
  endfunction : fvcm_dcode

  // page-zero word address inside the chosen segment
  function automatic logic [31:0] fvcm_pz_addr(input logic [2:0] s, input logic [7:0] w);
    fvcm_pz_addr = {1'b0, s, 20'h00000, w};
  endfunction : fvcm_pz_addr

  // pointer word as address: low 64KB of the segment, high bits zero
  function automatic logic [31:0] fvcm_low64k(input logic [2:0] s, input logic [14:0] p);
    fvcm_low64k = {1'b0, s, 13'h0000, p};
  endfunction : fvcm_low64k

  // page-zero words that hold parameters, never a handler pointer
  function automatic logic fvcm_data_word(input logic [7:0] w);
    fvcm_data_word = (w == FVCM_W_LEVEL) || (w == FVCM_W_IO_RET_HI) ||
      (w == FVCM_W_IO_RET_LO) || (w == FVCM_W_VSTK_PTR) ||
      (w == FVCM_W_NMASK) || (w == FVCM_W_VSTK_LIM) ||
      (w == FVCM_W_WIDE_EXTENDED_OP_ORG) || (w == FVCM_W_CTX_BASE) ||
      (w == FVCM_W_GATE_PTR) || (w == FVCM_W_NSTK_TOP) ||
      (w == FVCM_W_NFRAME) || (w == FVCM_W_NSTK_LIM) ||
      (w == FVCM_W_NXOP_ORG);
  endfunction : fvcm_data_word

  ////////////////////////////////////////////////////////////////////////
  // page-zero segment choice

  // translation off forces segment 0 physical; on uses the faulting segment
  logic [2:0] next_seg;
  assign next_seg = xlate_en ? fault_req.seg : 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // dispatch state machine

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      req <= '0;
      word <= 8'h00;
      seg <= 3'h0;
      hops <= 5'h00;
      lvl_zero <= 1'b1;
    end else begin
      case (state)
        S_IDLE: begin
          if (fault_valid) begin
            req <= fault_req;
            seg <= next_seg;
            word <= fvcm_slot(fault_req.kind);
            hops <= 5'h00;
            state <= S_LVL;
          end
        end
        S_LVL: state <= S_LVL_WAIT;
        S_LVL_WAIT: begin
          if (mem_rd_ok) begin
            lvl_zero <= (mem_rd_data == 16'h0000);
            state <= S_RD;
          end
        end
        S_RD: state <= S_WAIT;
        S_WAIT: begin
          if (mem_rd_ok) begin
            // bit 15 marks another hop; chains stay in the low 64KB
            if (fvcm_indir(req.kind) && mem_rd_data[15] && hops < FVCM_IND_MAX) begin
              hops <= hops + 5'h01;
              state <= S_RD;
            end else begin
              state <= S_DONE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // memory port

  logic [14:0] ptr;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_rd_req <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_phys <= 1'b0;
      ptr <= 15'h0000;
    end else begin
      mem_rd_req <= (state == S_LVL) || (state == S_RD);
      mem_phys <= !xlate_en;
      if (state == S_LVL) begin
        mem_addr <= fvcm_pz_addr(seg, FVCM_W_LEVEL);
      end else if (state == S_RD && hops == 5'h00) begin
        mem_addr <= fvcm_pz_addr(seg, word);
      end else if (state == S_RD) begin
        mem_addr <= fvcm_low64k(seg, ptr);
      end
      if (state == S_WAIT && mem_rd_ok) begin
        ptr <= mem_rd_data[14:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done <= 1'b0;
      busy <= 1'b0;
      result <= '0;
      bad_vector <= 1'b0;
    end else begin
      busy <= (state != S_IDLE) || fault_valid;
      done <= (state == S_DONE);
      if (state == S_DONE) begin
        // handler target in same segment, first 64KB only
        result.target <= fvcm_low64k(seg, ptr);
        result.base_level <= lvl_zero;
        result.acc_one <= fvcm_dcode(req.dcond, req.wide);
        result.acc_two <= req.size_prec;
        result.acc_two_we <= (req.kind == FVCM_F_DEC) &&
          (req.dcond == FVCM_D_MOVE_SRC || req.dcond == FVCM_D_OPCODE);
        // only segment 0 holds privileged pointers
        bad_vector <= (seg != 3'h0);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence SEQ_START;
    state == S_IDLE && fault_valid;
  endsequence
  AST_LVL_READ: assert property (@(posedge clk) disable iff (!rst_n)
    SEQ_START |-> ##2 (mem_rd_req && mem_addr[7:0] == FVCM_W_LEVEL))
    else $error("level word not read");
  AST_WINDOW: assert property (@(posedge clk) disable iff (!rst_n)
    mem_rd_req && mem_addr[27:8] == 20'h00000 && hops == 5'h00 && state == S_WAIT
      |-> mem_addr[7:0] <= FVCM_RSV_LAST)
    else $error("page-zero read past reserved area");
  AST_PHYS: assert property (@(posedge clk) disable iff (!rst_n)
    mem_rd_req && mem_phys |-> mem_addr[30:28] == 3'h0)
    else $error("physical page zero not in segment 0");
  AST_64K: assert property (@(posedge clk) disable iff (!rst_n)
    done |-> result.target[27:15] == 13'h0000)
    else $error("target past 64KB");
  AST_TARGET_SEG: assert property (@(posedge clk) disable iff (!rst_n)
    done |-> result.target[30:28] == seg)
    else $error("target segment wrong");
  AST_WIDE: assert property (@(posedge clk) disable iff (!rst_n)
    done && req.wide && req.dcond != FVCM_D_RETBLK |-> result.acc_one[15])
    else $error("wide code missing msb");
  AST_RETBLK: assert property (@(posedge clk) disable iff (!rst_n)
    done && req.dcond == FVCM_D_RETBLK |-> result.acc_one == FVCM_DC_RETBLK)
    else $error("return block code wrong");
  AST_DIRECT: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_WAIT && mem_rd_ok && !fvcm_indir(req.kind) |=> state == S_DONE)
    else $error("direct pointer followed");
  AST_SIZE: assert property (@(posedge clk) disable iff (!rst_n)
    done && result.acc_two_we |-> result.acc_two == req.size_prec)
    else $error("size lost");

  // handler slot and chain checks
  AST_DATA_WORD: assert property (@(posedge clk) disable iff (!rst_n)
    mem_rd_req && state == S_WAIT && hops == 5'h00 |-> !fvcm_data_word(mem_addr[7:0]))
    else $error("parameter word fetched as handler");
  AST_HOP_LIMIT: assert property (@(posedge clk) disable iff (!rst_n)
    hops <= FVCM_IND_MAX)
    else $error("indirect chain too long");
  AST_PAGE_DIRECT: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_WAIT && mem_rd_ok && req.kind == FVCM_F_PAGE |=> state == S_DONE)
    else $error("page handler pointer followed");

  // walk timing: each step two cycles after the answer before it
  sequence SEQ_LVL_ANS;
    state == S_LVL_WAIT && mem_rd_ok;
  endsequence
  sequence SEQ_LAST_ANS;
    state == S_WAIT && mem_rd_ok &&
      !(fvcm_indir(req.kind) && mem_rd_data[15] && hops < FVCM_IND_MAX);
  endsequence
  AST_SLOT_READ: assert property (@(posedge clk) disable iff (!rst_n)
    SEQ_LVL_ANS |-> ##2 (mem_rd_req && mem_addr == fvcm_pz_addr(seg, word)))
    else $error("handler slot not read");
  AST_LEVEL_SET: assert property (@(posedge clk) disable iff (!rst_n)
    SEQ_LVL_ANS |=> lvl_zero == ($past(mem_rd_data) == 16'h0000))
    else $error("level word not recorded");
  AST_DONE_AFTER: assert property (@(posedge clk) disable iff (!rst_n)
    SEQ_LAST_ANS |-> ##2 (done &&
      result.target == fvcm_low64k(seg, $past(mem_rd_data[14:0], 2))))
    else $error("handler target not delivered");

  // pulses, refusal and result fields
  AST_DONE_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    done |=> !done)
    else $error("done longer than one cycle");
  AST_REQ_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    mem_rd_req |=> !mem_rd_req)
    else $error("read request longer than one cycle");
  AST_REFUSE: assert property (@(posedge clk) disable iff (!rst_n)
    state != S_IDLE && fault_valid |=> $stable(req))
    else $error("request taken while busy");
  AST_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
    state != S_IDLE |=> busy)
    else $error("busy low during dispatch");
  AST_CODE_SET: assert property (@(posedge clk) disable iff (!rst_n)
    done |-> result.acc_one[14:0] <= 15'h0007)
    else $error("decimal code out of range");
  AST_SEG0_OK: assert property (@(posedge clk) disable iff (!rst_n)
    done && !bad_vector |-> result.target[30:28] == 3'h0)
    else $error("privileged pointer outside segment 0");
endmodule : fvcm_dispatch
`default_nettype wire

// >>> sim/testbench.sv
// testbench: self-checking bench for fvcm_dispatch
// assumes fvcm_pkg and fvcm_dispatch compiled first; bench answers memory reads
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fvcm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fault_valid = 1'b0;
  fvcm_req_s fault_req = '0;
  logic xlate_en = 1'b1;
  logic mem_rd_ok = 1'b0;
  logic [15:0] mem_rd_data = 16'h0000;
  logic busy, mem_rd_req, mem_phys, done, bad_vector, got_bad;
  logic [31:0] mem_addr;
  fvcm_res_s result;
  logic [15:0] mem [0:32767];
  logic [32:0] rd_log [$];
  logic [7:0] slot_of [0:10];
  int n_fail = 0;
  int checks = 0;
  int extra;
  fvcm_dispatch u_dut (.clk(clk), .rst_n(rst_n), .fault_valid(fault_valid),
    .fault_req(fault_req), .xlate_en(xlate_en), .busy(busy), .mem_rd_req(mem_rd_req),
    .mem_addr(mem_addr), .mem_phys(mem_phys), .mem_rd_ok(mem_rd_ok),
    .mem_rd_data(mem_rd_data), .done(done), .result(result), .bad_vector(bad_vector));
  initial begin
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // memory answers one cycle after a read; data inverts while not valid
  always @(posedge clk) begin
    mem_rd_ok <= mem_rd_req;
    mem_rd_data <= mem_rd_req ? mem[mem_addr[14:0]] : ~mem_rd_data;
    if (mem_rd_req === 1'b1) rd_log.push_back({mem_phys, mem_addr});
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  function automatic logic [32:0] pz(input logic ph, input logic [2:0] s, input logic [7:0] w);
    return {ph, 1'b0, s, 20'h0, w};
  endfunction : pz
  function automatic logic [31:0] hop(input logic [2:0] s, input logic [15:0] p);
    return {1'b0, s, 13'h0, p[14:0]};
  endfunction : hop
  task automatic run(input fvcm_fault_e k, input fvcm_dec_e d, input logic w,
                     input logic [2:0] s, input logic x, input bit poke);
    int i;
    rd_log.delete();
    @(posedge clk);
    fault_req <= '{kind: k, dcond: d, wide: w, seg: s, size_prec: {13'h0A5, s}};
    xlate_en <= x;
    fault_valid <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      fault_valid <= (poke && i == 2);
      if (poke && i == 2) fault_req.kind <= FVCM_F_ERR;
      #1;
      if (done === 1'b1) break;
    end
    got_bad = bad_vector;
    if (i == 200) begin
      check("done", 1'b0, 1'b1);
      close_out();
    end else begin
      extra = 0;
      repeat (20) begin
        @(posedge clk);
        #1;
        if (done === 1'b1) extra++;
      end
    end
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_slots();
    int k;
    mem[0] = 16'h0000;
    for (k = 0; k < 11; k++) mem[slot_of[k]] = 16'h0200 + slot_of[k];
    for (k = 0; k < 11; k++) begin
      run(fvcm_fault_e'(k), FVCM_D_NONE, 1'b0, 3'h0, 1'b1, 1'b0);
      check("level addr", rd_log[0], pz(1'b0, 3'h0, FVCM_W_LEVEL));
      check("slot addr", rd_log[1], pz(1'b0, 3'h0, slot_of[k]));
      check("reads", rd_log.size(), 2);
      check("vstk word", rd_log[1][7:0] == FVCM_W_VSTK_PTR, 1'b0);
      check("target", result.target, hop(3'h0, 16'h0200 + slot_of[k]));
      check("base", result.base_level, 1'b1);
      check("bad", got_bad, 1'b0);
    end
  endtask : t_slots
  task automatic t_indirect();
    mem[0] = 16'h0005;
    mem[FVCM_W_DEC_HND] = 16'h8300;
    mem[16'h0300] = 16'h8400;
    mem[16'h0400] = 16'h0555;
    run(FVCM_F_DEC, FVCM_D_NONE, 1'b0, 3'h0, 1'b1, 1'b0);
    check("hop1", rd_log[2], {1'b0, hop(3'h0, 16'h0300)});
    check("hop2", rd_log[3], {1'b0, hop(3'h0, 16'h0400)});
    check("target", result.target, hop(3'h0, 16'h0555));
    check("base", result.base_level, 1'b0);
    mem[FVCM_W_ERR_HND] = 16'h8600;
    run(FVCM_F_ERR, FVCM_D_NONE, 1'b0, 3'h0, 1'b1, 1'b0);
    check("direct", rd_log.size(), 2);
    check("target", result.target, hop(3'h0, 16'h0600));
  endtask : t_indirect
  task automatic t_segments();
    run(FVCM_F_FIX, FVCM_D_NONE, 1'b0, 3'h3, 1'b0, 1'b0);
    check("phys level", rd_log[0], pz(1'b1, 3'h0, FVCM_W_LEVEL));
    check("phys slot", rd_log[1], pz(1'b1, 3'h0, FVCM_W_FIX_HND));
    check("bad", got_bad, 1'b0);
    run(FVCM_F_FIX, FVCM_D_NONE, 1'b0, 3'h2, 1'b1, 1'b0);
    check("logical slot", rd_log[1], pz(1'b0, 3'h2, FVCM_W_FIX_HND));
    check("bad", got_bad, 1'b1);
  endtask : t_segments
  task automatic t_codes();
    int d;
    int w;
    logic [15:0] exp;
    for (d = 1; d < 10; d++) begin
      for (w = 0; w < 2; w++) begin
        run(FVCM_F_DEC, fvcm_dec_e'(d), w[0], 3'h0, 1'b1, 1'b0);
        exp = (d == 9) ? 16'h0006 : 16'(d - 1);
        if (w == 1 && d != 6) exp = exp | FVCM_WIDE_BIT;
        check("code", result.acc_one, exp);
        check("we", result.acc_two_we, (d == 3 || d == 4));
        if (d == 3 || d == 4) check("size", result.acc_two, 16'h0528);
      end
    end
  endtask : t_codes
  task automatic t_refuse();
    run(FVCM_F_FP, FVCM_D_NONE, 1'b0, 3'h0, 1'b1, 1'b1);
    check("target", result.target, hop(3'h0, 16'h0200 + FVCM_W_FP_HND));
    check("single", extra, 0);
    check("idle", busy, 1'b0);
  endtask : t_refuse
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    slot_of = '{FVCM_W_IO_HND, FVCM_W_VSTK_HND, FVCM_W_BRK_HND, FVCM_W_WSTK_HND,
      FVCM_W_PAGE_HND, FVCM_W_PROT_HND, FVCM_W_FIX_HND, FVCM_W_NSTK_HND, FVCM_W_FP_HND,
      FVCM_W_DEC_HND, FVCM_W_ERR_HND};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("reset flags", {done, busy, mem_rd_req, bad_vector}, 4'h0);
    check("reset target", result.target, 32'h0);
    t_slots();
    t_codes();
    t_indirect();
    t_segments();
    t_refuse();
    close_out();
  end
endmodule : testbench
`default_nettype wire
